// file: common/psu_status_pkg.sv
// Package with command codes, bit positions and mask defaults of the status bank.
package psu_status_pkg;
  localparam logic [7:0] CMD_WORD = 8'h0079;
  localparam logic [7:0] CMD_VOUT = 8'h007A;
  localparam logic [7:0] CMD_IOUT = 8'h007B;
  localparam logic [7:0] CMD_INPUT = 8'h007C;
  localparam logic [7:0] CMD_FANS = 8'h0081;
  localparam logic [7:0] CMD_MASK = 8'h001B;
  localparam logic [1:0] INST_NOPAGE = 2'h0;
  localparam logic [1:0] INST_BOARD = 2'h1;
  localparam logic [1:0] INST_ENGINE = 2'h2;
  localparam logic [1:0] INST_ALL = 2'h3;
  localparam int VOUT_OV = 7;
  localparam int VOUT_UV = 4;
  localparam int IOUT_OCF = 7;
  localparam int IOUT_OCW = 5;
  localparam int IOUT_OPF = 1;
  localparam int IOUT_OPW = 0;
  localparam int IN_UVW = 5;
  localparam int IN_UVF = 4;
  localparam int IN_OFFLOW = 3;
  localparam int FAN_FLT = 7;
  localparam int FAN_WRN = 5;
  localparam int WL_OFF = 6;
  localparam int WL_OC = 4;
  localparam int WL_INUV = 3;
  localparam int WL_TEMP = 2;
  localparam int WL_COMM = 1;
  localparam int WH_VOUT = 15;
  localparam int WH_IOUT = 14;
  localparam int WH_INPUT = 13;
  localparam int WH_FANS = 10;
  localparam logic [7:0] VOUT_USED = 8'h0090;
  localparam logic [7:0] IOUT_USED = 8'h00B3;
  localparam logic [7:0] INPUT_USED = 8'h0038;
  localparam logic [7:0] FANS_USED = 8'h00A0;
  localparam logic [7:0] MASK_VOUT_DEF = 8'h0090;
  localparam logic [7:0] MASK_IOUT_DEF_A = 8'h00B3;
  localparam logic [7:0] MASK_IOUT_DEF_E = 8'h0093;
  localparam logic [7:0] MASK_INPUT_DEF_A = 8'h0038;
  localparam logic [7:0] MASK_INPUT_DEF_E = 8'h0028;
  localparam logic [7:0] MASK_FANS_DEF = 8'h00A0;

  // Condition inputs presented in one bundle.
  typedef struct packed {
    logic overvoltage_fault;
    logic output_low_fault;
    logic overcurrent_fault;
    logic overcurrent_warning;
    logic overpower_fault;
    logic overpower_warning;
    logic input_low_warning;
    logic input_low_fault;
    logic input_off_low;
    logic fan_fault;
    logic fan_warning;
    logic temp_any;
    logic comm_fault_flag;
  } events_t;

  // One status instance.
  typedef struct packed {
    logic [7:0] vout;
    logic [7:0] iout;
    logic [7:0] supply_in;
    logic [7:0] fans;
  } status_t;
endpackage : psu_status_pkg

// file: logic/power_status_alert_bank.sv
// Sticky status bank with three instances, summary word and alert masking.
`timescale 1ns/100ps

module power_status_alert_bank (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Condition inputs from outside the clock domain.
  input wire psu_status_pkg::events_t EVENTS,
  // Command port from the bus transport; INST selects unpaged, page 00h, page 01h or all three.
  input wire logic CMD_WR,
  input wire logic CMD_CLEAR_ALL,
  input wire logic [7:0] CMD_CODE,
  input wire logic [1:0] CMD_INST,
  input wire logic [7:0] CMD_WDATA,
  input wire logic CMD_RD,
  // Read data.
  output logic [15:0] RD_DATA,
  output logic RD_VALID,
  output logic RD_ERR,
  // Alert output, active low.
  output logic ALERT_N
);

  psu_status_pkg::events_t ev_meta;
  psu_status_pkg::events_t ev_sync;
  psu_status_pkg::status_t st [3];
  psu_status_pkg::status_t msk [3];
  logic [2:0] inst_hit;
  logic alert_any;
  logic mask_wr;
  logic mask_armed;
  logic [7:0] mask_target;

  // Returns the summary word for one instance.
  function automatic logic [15:0] summary(input psu_status_pkg::status_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[psu_status_pkg::WL_OFF] = s.vout[psu_status_pkg::VOUT_OV]
        | s.vout[psu_status_pkg::VOUT_UV] | s.iout[psu_status_pkg::IOUT_OCF]
        | s.iout[psu_status_pkg::IOUT_OPF] | s.supply_in[psu_status_pkg::IN_OFFLOW]
        | s.fans[psu_status_pkg::FAN_FLT];
    w[psu_status_pkg::WL_OC] = s.iout[psu_status_pkg::IOUT_OCF];
    w[psu_status_pkg::WL_INUV] = s.supply_in[psu_status_pkg::IN_UVF];
    w[psu_status_pkg::WL_TEMP] = ev_sync.temp_any;
    w[psu_status_pkg::WL_COMM] = ev_sync.comm_fault_flag;
    w[psu_status_pkg::WH_VOUT] = |s.vout;
    w[psu_status_pkg::WH_IOUT] = |s.iout;
    w[psu_status_pkg::WH_INPUT] = |s.supply_in;
    w[psu_status_pkg::WH_FANS] = |s.fans;
    return w;
  endfunction : summary

  // Maps the synchronised conditions onto status byte positions.
  function automatic psu_status_pkg::status_t raw_bits(input psu_status_pkg::events_t e);
    psu_status_pkg::status_t r;
    r = '0;
    r.vout[psu_status_pkg::VOUT_OV] = e.overvoltage_fault;
    r.vout[psu_status_pkg::VOUT_UV] = e.output_low_fault;
    r.iout[psu_status_pkg::IOUT_OCF] = e.overcurrent_fault;
    r.iout[psu_status_pkg::IOUT_OCW] = e.overcurrent_warning;
    r.iout[psu_status_pkg::IOUT_OPF] = e.overpower_fault;
    r.iout[psu_status_pkg::IOUT_OPW] = e.overpower_warning;
    r.supply_in[psu_status_pkg::IN_UVW] = e.input_low_warning;
    r.supply_in[psu_status_pkg::IN_UVF] = e.input_low_fault;
    r.supply_in[psu_status_pkg::IN_OFFLOW] = e.input_off_low;
    r.fans[psu_status_pkg::FAN_FLT] = e.fan_fault;
    r.fans[psu_status_pkg::FAN_WRN] = e.fan_warning;
    return r;
  endfunction : raw_bits

  // Loads one mask byte of an instance; the target names the status command.
  function automatic psu_status_pkg::status_t mask_load(input psu_status_pkg::status_t m,
      input logic [7:0] tgt, input logic [7:0] d);
    psu_status_pkg::status_t r;
    r = m;
    case (tgt)
      psu_status_pkg::CMD_VOUT: r.vout = d;
      psu_status_pkg::CMD_IOUT: r.iout = d;
      psu_status_pkg::CMD_INPUT: r.supply_in = d;
      psu_status_pkg::CMD_FANS: r.fans = d;
      default: r = m;
    endcase
    return r;
  endfunction : mask_load

  // True for the command codes that the read path answers.
  function automatic logic known_code(input logic [7:0] c);
    return (c == psu_status_pkg::CMD_WORD) || (c == psu_status_pkg::CMD_VOUT)
        || (c == psu_status_pkg::CMD_IOUT) || (c == psu_status_pkg::CMD_INPUT)
        || (c == psu_status_pkg::CMD_FANS);
  endfunction : known_code

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ev_meta <= '0;
      ev_sync <= '0;
    end else begin
      ev_meta <= EVENTS;
      ev_sync <= ev_meta;
    end
  end

  // Instance selection: paged writes reach one page, plain writes the unpaged one, INST_ALL writes reach all three.
  always_comb begin
    inst_hit = 3'b000;
    case (CMD_INST)
      psu_status_pkg::INST_NOPAGE: inst_hit = 3'b001;
      psu_status_pkg::INST_BOARD: inst_hit = 3'b010;
      psu_status_pkg::INST_ENGINE: inst_hit = 3'b100;
      psu_status_pkg::INST_ALL: inst_hit = 3'b111;
      default: inst_hit = 3'b000;
    endcase
  end

  // Mask command is two writes: the first names the status command, the second
  // carries the mask byte for it. A lone first write leaves the masks untouched.
  assign mask_wr = CMD_WR && (CMD_CODE == psu_status_pkg::CMD_MASK);

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mask_armed <= 1'b0;
      mask_target <= 8'h00;
    end else if (mask_wr) begin
      mask_armed <= ~mask_armed;
      if (!mask_armed) begin
        mask_target <= CMD_WDATA;
      end
    end
  end

  a_mask_arm: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      mask_wr |=> (mask_armed != $past(mask_armed)))
    else $error("mask command phase did not advance");
  a_mask_target: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (mask_wr && !mask_armed) |=> (mask_target == $past(CMD_WDATA)))
    else $error("mask target not taken");
  a_mask_load: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (mask_wr && mask_armed && inst_hit[1] && mask_target == psu_status_pkg::CMD_IOUT)
      |=> (msk[1].iout == $past(CMD_WDATA)))
    else $error("page 00h current mask not loaded");

  localparam psu_status_pkg::status_t USED = {psu_status_pkg::VOUT_USED,
      psu_status_pkg::IOUT_USED, psu_status_pkg::INPUT_USED, psu_status_pkg::FANS_USED};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_inst
      psu_status_pkg::status_t clr;
      psu_status_pkg::status_t set;
      psu_status_pkg::status_t next_st;
      always_comb begin
        clr = '0;
        if (CMD_WR && inst_hit[gi]) begin
          case (CMD_CODE)
            psu_status_pkg::CMD_VOUT: clr.vout = (gi == 0) ? CMD_WDATA : 8'h00;
            psu_status_pkg::CMD_IOUT: clr.iout = CMD_WDATA;
            psu_status_pkg::CMD_INPUT: clr.supply_in = CMD_WDATA;
            psu_status_pkg::CMD_FANS: clr.fans = (gi == 0) ? CMD_WDATA : 8'h00;
            default: clr = '0;
          endcase
        end
        set = raw_bits(ev_sync);
        if (gi != 0) begin
          set.vout = 8'h00;
          set.fans = 8'h00;
        end
        next_st = ((st[gi] & ~clr) | set) & USED;
      end
      always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          st[gi] <= '0;
        end else if (CMD_CLEAR_ALL) begin
          st[gi] <= '0;
        end else begin
          st[gi] <= next_st;
        end
      end
      // Only page 01h differs: its current warning and input fault are unmasked.
      localparam psu_status_pkg::status_t MDEF = (gi == 2) ?
          {psu_status_pkg::MASK_VOUT_DEF, psu_status_pkg::MASK_IOUT_DEF_E,
           psu_status_pkg::MASK_INPUT_DEF_E, psu_status_pkg::MASK_FANS_DEF} :
          {psu_status_pkg::MASK_VOUT_DEF, psu_status_pkg::MASK_IOUT_DEF_A,
           psu_status_pkg::MASK_INPUT_DEF_A, psu_status_pkg::MASK_FANS_DEF};
      // Second phase of the mask command loads the named byte of each hit instance.
      always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          msk[gi] <= MDEF;
        end else if (mask_wr && mask_armed && inst_hit[gi]) begin
          msk[gi] <= mask_load(msk[gi], mask_target, CMD_WDATA);
        end
      end
      a_sticky_hold: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
          (!CMD_CLEAR_ALL && !CMD_WR) |=> ((st[gi] & $past(st[gi])) == $past(st[gi])))
        else $error("status bit dropped without a clear");
      a_event_sets: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
          (ev_sync.overcurrent_fault && !CMD_CLEAR_ALL) |=> st[gi].iout[psu_status_pkg::IOUT_OCF])
        else $error("overcurrent fault not latched");
      a_clear_all: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
          CMD_CLEAR_ALL |=> (st[gi] == '0))
        else $error("clear all left a bit set");
    end
  endgenerate

  a_pages_narrow: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (st[1].fans | st[2].fans | st[1].vout | st[2].vout) == 8'h00)
    else $error("paged instance holds an unpaged byte");
  a_engine_own: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (CMD_WR && !CMD_CLEAR_ALL && !inst_hit[2]) |=>
      ((st[2] & $past(st[2])) == $past(st[2])))
    else $error("page 01h bit cleared by another manager");
  a_warn_sets: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (ev_sync.input_low_warning && !CMD_CLEAR_ALL) |=>
      st[2].supply_in[psu_status_pkg::IN_UVW])
    else $error("input low warning not latched");

  // Alert: any set bit whose mask bit is zero in its instance.
  always_comb begin
    alert_any = 1'b0;
    for (int i = 0; i < 3; i++) begin
      alert_any = alert_any | (|(st[i] & ~msk[i]));
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ALERT_N <= 1'b1;
    end else begin
      ALERT_N <= ~alert_any;
    end
  end

  a_alert_follows: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      alert_any |=> !ALERT_N)
    else $error("alert not asserted for unmasked bit");
  a_alert_idle: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      !alert_any |=> ALERT_N)
    else $error("alert held with no unmasked bit");
  a_alert_release: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      CMD_CLEAR_ALL |=> ##1 ALERT_N)
    else $error("alert held after clear all");

  // Read path: one-cycle registered answer.
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RD_DATA <= 16'h0000;
      RD_VALID <= 1'b0;
      RD_ERR <= 1'b0;
    end else begin
      RD_VALID <= CMD_RD;
      RD_ERR <= 1'b0;
      RD_DATA <= 16'h0000;
      if (CMD_RD) begin
        case (CMD_CODE)
          psu_status_pkg::CMD_WORD:
            RD_DATA <= (CMD_INST == psu_status_pkg::INST_ENGINE) ? summary(st[2]) :
                (CMD_INST == psu_status_pkg::INST_BOARD) ? summary(st[1]) :
                summary(st[0]);
          psu_status_pkg::CMD_VOUT: RD_DATA <= {8'h00, st[0].vout};
          psu_status_pkg::CMD_IOUT:
            RD_DATA <= {8'h00, (CMD_INST == psu_status_pkg::INST_ENGINE) ? st[2].iout :
                (CMD_INST == psu_status_pkg::INST_BOARD) ? st[1].iout : st[0].iout};
          psu_status_pkg::CMD_INPUT:
            RD_DATA <= {8'h00, (CMD_INST == psu_status_pkg::INST_ENGINE) ? st[2].supply_in :
                (CMD_INST == psu_status_pkg::INST_BOARD) ? st[1].supply_in :
                st[0].supply_in};
          psu_status_pkg::CMD_FANS: RD_DATA <= {8'h00, st[0].fans};
          default: RD_ERR <= 1'b1;
        endcase
      end
    end
  end

  a_read_answer: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      CMD_RD |=> RD_VALID)
    else $error("read not answered next cycle");
  a_read_quiet: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      !CMD_RD |=> !RD_VALID)
    else $error("read answer without a request");
  a_read_err: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (CMD_RD && !known_code(CMD_CODE)) |=> RD_ERR)
    else $error("unknown read code not refused");
  a_fans_read: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (CMD_RD && CMD_CODE == psu_status_pkg::CMD_FANS) |=>
      (RD_DATA == {8'h00, $past(st[0].fans)}))
    else $error("fan byte read wrong");
  a_summary_nowr: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
      (CMD_WR && CMD_CODE == psu_status_pkg::CMD_WORD && !CMD_CLEAR_ALL) |=>
      (st[0] == ((($past(st[0])) | raw_bits($past(ev_sync))) & USED)))
    else $error("summary write changed status");
endmodule : power_status_alert_bank

// file: dv/host_model.sv
// Host management controller model that issues status commands one at a time.
`timescale 1ns/100ps
module host_model (
  // Clock.
  input wire logic clk,
  // Command strobes and fields.
  output logic wr,
  output logic rd,
  output logic clr_all,
  output logic [7:0] code,
  output logic [1:0] inst,
  output logic [7:0] wdata
);
  initial begin
    {wr, rd, clr_all} = 3'b000;
    code = 8'h00;
    inst = 2'h0;
    wdata = 8'h00;
  end

  // One strobe per call. After a call the fields show inverted values while idle, so stale data never counts.
  task automatic op(input logic [2:0] kind, input logic [7:0] cd, input logic [1:0] in,
                    input logic [7:0] d);
    @(posedge clk);
    #1;
    {wr, rd, clr_all} = kind;
    code = cd;
    inst = in;
    wdata = d;
    @(posedge clk);
    #1;
    {wr, rd, clr_all} = 3'b000;
    code = ~cd;
    inst = ~in;
    wdata = ~d;
  endtask : op
endmodule : host_model

// file: dv/power_status_alert_bank_bench.sv
// Self-checking bench of the status alert bank driven through the host model.
`timescale 1ns/100ps
module power_status_alert_bank_bench;
  logic core_clk;
  logic sys_rst;
  logic wr;
  logic rd;
  logic clr_all;
  logic [7:0] code;
  logic [1:0] inst;
  logic [7:0] wdata;
  logic [15:0] rd_data;
  logic rd_valid;
  logic rd_err;
  logic alert_n;
  psu_status_pkg::events_t events;
  logic [16:0] exp_q[$];
  logic [15:0] seed = 16'h3E00;
  int error_cnt = 0;
  int checks = 0;

  host_model host (.clk(core_clk), .wr(wr), .rd(rd), .clr_all(clr_all), .code(code),
    .inst(inst), .wdata(wdata));
  power_status_alert_bank dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .EVENTS(events),
    .CMD_WR(wr), .CMD_CLEAR_ALL(clr_all), .CMD_CODE(code), .CMD_INST(inst),
    .CMD_WDATA(wdata), .CMD_RD(rd), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .RD_ERR(rd_err), .ALERT_N(alert_n));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic get(input logic [7:0] cd, input logic [1:0] in, input logic [16:0] exp);
    exp_q.push_back(exp);
    host.op(3'b010, cd, in, 8'h00);
  endtask : get

  task automatic pulse(input logic [12:0] ev);
    @(posedge core_clk);
    #1;
    events = psu_status_pkg::events_t'(ev);
    repeat (5) @(posedge core_clk);
    #1;
    events = '0;
    repeat (6) @(posedge core_clk);
  endtask : pulse

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic results;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // Results are read at the falling edge, where registered outputs have settled.
  always @(negedge core_clk) begin
    if (rd_valid === 1'b1 || rd_err === 1'b1) begin
      if (exp_q.size() == 0) check(17'h1_FFFF, 17'h0_0000);
      else check({rd_err, rd_err ? 16'h0000 : rd_data}, exp_q.pop_front());
    end
  end

  initial begin
    #200000;
    error_cnt++;
    results();
  end

  initial begin
    sys_rst = 1'b1;
    events = '0;
    repeat (12) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    check({16'h0000, alert_n}, 17'h0_0001);
    for (int i = 0; i < 3; i++) get(psu_status_pkg::CMD_IOUT, i[1:0], 17'h0_0000);
    $display("test reset done");
    pulse(13'h0600);
    for (int i = 0; i < 3; i++) get(psu_status_pkg::CMD_IOUT, i[1:0], 17'h0_00A0);
    get(psu_status_pkg::CMD_WORD, psu_status_pkg::INST_NOPAGE, 17'h0_4050);
    check({16'h0000, alert_n}, 17'h0_0000);
    host.op(3'b100, psu_status_pkg::CMD_IOUT, psu_status_pkg::INST_BOARD, 8'h80);
    host.op(3'b100, psu_status_pkg::CMD_WORD, psu_status_pkg::INST_NOPAGE, 8'hFF);
    get(psu_status_pkg::CMD_IOUT, psu_status_pkg::INST_BOARD, 17'h0_0020);
    get(psu_status_pkg::CMD_IOUT, psu_status_pkg::INST_ENGINE, 17'h0_00A0);
    get(psu_status_pkg::CMD_WORD, psu_status_pkg::INST_NOPAGE, 17'h0_4050);
    host.op(3'b100, psu_status_pkg::CMD_IOUT, psu_status_pkg::INST_ENGINE, 8'h20);
    repeat (3) @(posedge core_clk);
    check({16'h0000, alert_n}, 17'h0_0001);
    $display("test latch and clear done");
    pulse(13'h1068);
    get(psu_status_pkg::CMD_VOUT, psu_status_pkg::INST_NOPAGE, 17'h0_0080);
    for (int i = 0; i < 3; i++) get(psu_status_pkg::CMD_INPUT, i[1:0], 17'h0_0030);
    get(psu_status_pkg::CMD_FANS, psu_status_pkg::INST_NOPAGE, 17'h0_0080);
    check({16'h0000, alert_n}, 17'h0_0000);
    host.op(3'b100, psu_status_pkg::CMD_FANS, psu_status_pkg::INST_NOPAGE, 8'h80);
    get(psu_status_pkg::CMD_FANS, psu_status_pkg::INST_NOPAGE, 17'h0_0000);
    get(8'h00, psu_status_pkg::INST_NOPAGE, 17'h1_0000);
    host.op(3'b001, 8'h00, psu_status_pkg::INST_ALL, 8'h00);
    get(psu_status_pkg::CMD_VOUT, psu_status_pkg::INST_NOPAGE, 17'h0_0000);
    get(psu_status_pkg::CMD_INPUT, psu_status_pkg::INST_ENGINE, 17'h0_0000);
    check({16'h0000, alert_n}, 17'h0_0001);
    $display("test clear all done");
    host.op(3'b100, psu_status_pkg::CMD_MASK, psu_status_pkg::INST_BOARD,
      psu_status_pkg::CMD_IOUT);
    host.op(3'b100, psu_status_pkg::CMD_MASK, psu_status_pkg::INST_BOARD, 8'h00);
    pulse(13'h0400);
    check({16'h0000, alert_n}, 17'h0_0000);
    get(psu_status_pkg::CMD_IOUT, psu_status_pkg::INST_BOARD, 17'h0_0080);
    host.op(3'b100, psu_status_pkg::CMD_IOUT, psu_status_pkg::INST_BOARD, 8'h80);
    repeat (3) @(posedge core_clk);
    check({16'h0000, alert_n}, 17'h0_0001);
    @(posedge core_clk);
    #1;
    sys_rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    check({16'h0000, alert_n}, 17'h0_0001);
    pulse(13'h0400);
    check({16'h0000, alert_n}, 17'h0_0001);
    host.op(3'b001, 8'h00, psu_status_pkg::INST_ALL, 8'h00);
    $display("test mask and reset done");
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      pulse(seed[12:0] & 13'h0780);
      get(psu_status_pkg::CMD_IOUT, psu_status_pkg::INST_ENGINE,
        {9'h000, seed[10], 1'b0, seed[9], 3'b000, seed[8], seed[7]});
      host.op(3'b001, 8'h00, psu_status_pkg::INST_ALL, 8'h00);
    end
    $display("test random events done");
    for (int n = 0; n < 20 && exp_q.size() > 0; n++) @(posedge core_clk);
    if (exp_q.size() > 0) error_cnt++;
    results();
  end
endmodule : power_status_alert_bank_bench
